//--- rtl/smrc_defs.svh
// Constants for the sleep mode and reset controller
`ifndef SMRC_DEFS_SVH
`define SMRC_DEFS_SVH
`define SMRC_PORT_W 8
`define SMRC_NPORT 4
`define SMRC_MODE_W 3
`define SMRC_MODE_IDLE 3'h0
`define SMRC_MODE_ADCNR 3'h1
`define SMRC_MODE_PDOWN 3'h2
`define SMRC_MODE_PSAVE 3'h3
`define SMRC_MODE_STBY 3'h6
`define SMRC_MODE_XSTBY 3'h7
`define SMRC_RST_MIN_NS 1500
`define SMRC_CLK_NS 20
`define SMRC_RST_CYC ((`SMRC_RST_MIN_NS + `SMRC_CLK_NS - 1) / `SMRC_CLK_NS)
`define SMRC_CNT_W 7
`define SMRC_TDO_SHIFT_DR 4'h4
`define SMRC_TDO_SHIFT_IR 4'hB
`define SMRC_JTAG_PORT 2
`define SMRC_TDI_BIT 5
`define SMRC_TMS_BIT 3
`define SMRC_TCK_BIT 2
`endif

//--- rtl/smrc_pkg.sv
// Types for the sleep mode and reset controller
package smrc_pkg;
  typedef enum logic [1:0] {SMRC_RUN, SMRC_SLEEP, SMRC_WAKE} smrc_state_t;
  // Clock and module gate enables, one bit each
  typedef struct packed {
    logic cpu;
    logic osc;
    logic atimer;
    logic adc;
    logic io;
  } smrc_gate_t;
  // Wake sources presented to the sequencer
  typedef struct packed {
    logic ext_int;
    logic atimer_int;
    logic adc_int;
    logic io_int;
  } smrc_wake_t;
endpackage

//--- rtl/smrc_port_ctl.sv
// One 8-bit port pin control with reset tri-state and pull-ups
`timescale 1ns/1ps
`include "smrc_defs.svh"
module smrc_port_ctl
  import smrc_pkg::*;
(
  input wire logic core_clk, // System clock
  input wire logic reset, // Any reset source, async
  input wire logic [`SMRC_PORT_W-1:0] dir, // 1 = drive pin
  input wire logic [`SMRC_PORT_W-1:0] data, // Output data
  input wire logic [`SMRC_PORT_W-1:0] force_pu, // Pull-up kept in reset
  output logic [`SMRC_PORT_W-1:0] pin_o, // Pin output value
  output logic [`SMRC_PORT_W-1:0] pin_oe_n, // Low while driving
  output logic [`SMRC_PORT_W-1:0] pu_en // Pull-up enable
);
  logic [`SMRC_PORT_W-1:0] pu_req;
  logic [`SMRC_PORT_W-1:0] pu_next;

  // Pull-up per bit when input and data bit set
  assign pu_req = ~dir & data;
  // Forced pull-ups survive reset, software ones drop
  assign pu_next = force_pu | (reset ? '0 : pu_req);

  // Tri-state asynchronously on reset
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pin_o <= '0;
      pin_oe_n <= '1;
    end else begin
      pin_o <= data;
      pin_oe_n <= ~dir;
    end
  end

  // Pull-ups have no async clear so forced ones stay on
  always_ff @(posedge core_clk) begin
    pu_en <= pu_next;
  end
endmodule

//--- rtl/smrc_top.sv
// Sleep mode sequencer, reset pin filter and pin reset control
// Behaviour
// - Six selectable sleep modes gate clocks
// - Idle stops core, peripherals keep running
// - Power-down freezes oscillator, external wake only
// - Power-save keeps asynchronous timer running
// - Noise reduction keeps timer and converter
// - Standby keeps oscillator running, rest sleeps
// - Extended standby keeps oscillator and timer
// - Reset pin low past minimum resets
// - Reset tri-states all port pins asynchronously
// - JTAG pull-ups stay active during reset
// - TDO tri-stated except in shift states
// - Per-bit pull-up enable on each port
`timescale 1ns/1ps
`include "smrc_defs.svh"
module smrc_top
  import smrc_pkg::*;
(
  input wire logic core_clk, // 50 MHz system clock
  input wire logic reset, // Power-on reset, async high
  input wire logic ext_rst_n, // External reset pin
  input wire logic sleep_en, // Sleep enable control
  input wire logic sleep_instr, // Sleep instruction pulse
  input wire logic [`SMRC_MODE_W-1:0] sleep_mode, // Selected mode
  input wire smrc_wake_t wake, // Wake sources
  input wire logic jtag_en, // JTAG interface enabled
  input wire logic [3:0] tap_state, // TAP controller state
  input wire logic tap_tdo, // TDO data from TAP
  input wire logic [`SMRC_NPORT*`SMRC_PORT_W-1:0] port_dir, // Direction bits
  input wire logic [`SMRC_NPORT*`SMRC_PORT_W-1:0] port_data, // Data bits
  output smrc_gate_t gate_q, // Clock and module enables
  output smrc_state_t state_q, // Sequencer state
  output logic sys_rst_q, // Internal reset to device
  output logic tdo_o_q, // TDO pin value
  output logic tdo_oe_n_q, // TDO enable, low drives
  output logic [`SMRC_NPORT*`SMRC_PORT_W-1:0] pin_o, // Pin values
  output logic [`SMRC_NPORT*`SMRC_PORT_W-1:0] pin_oe_n, // Low drives
  output logic [`SMRC_NPORT*`SMRC_PORT_W-1:0] pu_en // Pull-ups
);
  localparam int unsigned RST_CYC = `SMRC_RST_CYC;
  localparam logic [`SMRC_CNT_W-1:0] RST_CNT = RST_CYC[`SMRC_CNT_W-1:0];

  logic ext_s1_q;
  logic ext_s2_q;
  logic [`SMRC_CNT_W-1:0] rst_cnt_q;
  logic [`SMRC_CNT_W-1:0] rst_cnt_d;
  logic ext_rst_q;
  logic any_rst;
  smrc_state_t state_d;
  smrc_gate_t gate_d;
  smrc_gate_t sleep_gate;
  logic [`SMRC_MODE_W-1:0] mode_q;
  logic wake_ok;
  logic go_sleep;
  logic enter;
  smrc_gate_t entry_gate;
  logic tdo_shift;
  logic [`SMRC_NPORT*`SMRC_PORT_W-1:0] jtag_pu;

  // Reset pin synchroniser
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ext_s1_q <= 1'b1;
      ext_s2_q <= 1'b1;
    end else begin
      ext_s1_q <= ext_rst_n;
      ext_s2_q <= ext_s1_q;
    end
  end

  // Low time counter on the reset pin
  assign rst_cnt_d = ext_s2_q ? '0 :
                     (rst_cnt_q == RST_CNT) ? rst_cnt_q : rst_cnt_q + 1'b1;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rst_cnt_q <= '0;
      ext_rst_q <= 1'b0;
    end else begin
      rst_cnt_q <= rst_cnt_d;
      ext_rst_q <= (rst_cnt_d == RST_CNT);
    end
  end

  // Pin low also resets without a clock once past the filter
  assign any_rst = reset | ext_rst_q;

  always_ff @(posedge core_clk or posedge any_rst) begin
    if (any_rst) begin
      sys_rst_q <= 1'b1;
    end else begin
      sys_rst_q <= 1'b0;
    end
  end

  // Running enables per sleep mode: cpu osc atimer adc io
  always_comb begin
    unique case (mode_q)
      `SMRC_MODE_IDLE: sleep_gate = '{cpu: 1'b0, osc: 1'b1, atimer: 1'b1,
                                     adc: 1'b1, io: 1'b1};
      `SMRC_MODE_ADCNR: sleep_gate = '{cpu: 1'b0, osc: 1'b1, atimer: 1'b1,
                                      adc: 1'b1, io: 1'b0};
      `SMRC_MODE_PDOWN: sleep_gate = '{cpu: 1'b0, osc: 1'b0, atimer: 1'b0,
                                      adc: 1'b0, io: 1'b0};
      `SMRC_MODE_PSAVE: sleep_gate = '{cpu: 1'b0, osc: 1'b0, atimer: 1'b1,
                                      adc: 1'b0, io: 1'b0};
      `SMRC_MODE_STBY: sleep_gate = '{cpu: 1'b0, osc: 1'b1, atimer: 1'b0,
                                     adc: 1'b0, io: 1'b0};
      `SMRC_MODE_XSTBY: sleep_gate = '{cpu: 1'b0, osc: 1'b1, atimer: 1'b1,
                                      adc: 1'b0, io: 1'b0};
      default: sleep_gate = '1; // Reserved codes keep every enable on
    endcase
  end

  // Wake sources each mode allows
  always_comb begin
    unique case (mode_q)
      `SMRC_MODE_IDLE: wake_ok = |wake;
      `SMRC_MODE_ADCNR: wake_ok = wake.ext_int | wake.atimer_int | wake.adc_int;
      `SMRC_MODE_PSAVE, `SMRC_MODE_XSTBY: wake_ok = wake.ext_int | wake.atimer_int;
      `SMRC_MODE_PDOWN, `SMRC_MODE_STBY: wake_ok = wake.ext_int;
      default: wake_ok = 1'b1;
    endcase
  end

  // Sleep only with enable and instruction together
  assign go_sleep = sleep_en & sleep_instr;

  // Sleep request taken on this edge, with the pattern it enters
  assign enter = (state_q == SMRC_RUN) & go_sleep;
  assign entry_gate = sleep_gate_of(sleep_mode);

  // Sequencer next state and gates
  always_comb begin
    state_d = state_q;
    gate_d = '1;
    unique case (state_q)
      SMRC_RUN: begin
        if (go_sleep) begin
          state_d = SMRC_SLEEP;
        end
      end
      SMRC_SLEEP: begin
        gate_d = sleep_gate;
        if (wake_ok) begin
          state_d = SMRC_WAKE;
          gate_d = '1;
        end
      end
      SMRC_WAKE: begin
        state_d = SMRC_RUN;
      end
    endcase
  end

  // Mode captured at sleep entry, state and gates registered
  always_ff @(posedge core_clk or posedge any_rst) begin
    if (any_rst) begin
      state_q <= SMRC_RUN;
      gate_q <= '1;
      mode_q <= `SMRC_MODE_IDLE;
    end else begin
      state_q <= state_d;
      gate_q <= enter ? entry_gate : gate_d;
      mode_q <= enter ? sleep_mode : mode_q;
    end
  end

  // Gate pattern lookup for the mode being entered
  function automatic smrc_gate_t sleep_gate_of(input logic [`SMRC_MODE_W-1:0] m);
    smrc_gate_t g;
    g = '1;
    g.cpu = 1'b0;
    unique case (m)
      `SMRC_MODE_IDLE: g = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
      `SMRC_MODE_ADCNR: g = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
      `SMRC_MODE_PDOWN: g = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
      `SMRC_MODE_PSAVE: g = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
      `SMRC_MODE_STBY: g = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
      `SMRC_MODE_XSTBY: g = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
      default: g = '1;
    endcase
    return g;
  endfunction

  // TDO drives only in shift states
  assign tdo_shift = jtag_en & ((tap_state == `SMRC_TDO_SHIFT_DR) |
                                (tap_state == `SMRC_TDO_SHIFT_IR));

  always_ff @(posedge core_clk or posedge any_rst) begin
    if (any_rst) begin
      tdo_o_q <= 1'b0;
      tdo_oe_n_q <= 1'b1;
    end else begin
      tdo_o_q <= tap_tdo;
      tdo_oe_n_q <= ~tdo_shift;
    end
  end

  // JTAG pull-ups on TDI, TMS, TCK of the third port
  always_comb begin
    jtag_pu = '0;
    jtag_pu[`SMRC_JTAG_PORT*`SMRC_PORT_W+`SMRC_TDI_BIT] = jtag_en;
    jtag_pu[`SMRC_JTAG_PORT*`SMRC_PORT_W+`SMRC_TMS_BIT] = jtag_en;
    jtag_pu[`SMRC_JTAG_PORT*`SMRC_PORT_W+`SMRC_TCK_BIT] = jtag_en;
  end

  // One pin controller per port
  for (genvar p = 0; p < `SMRC_NPORT; p++) begin : g_port
    smrc_port_ctl u_port (
      .core_clk(core_clk),
      .reset(any_rst),
      .dir(port_dir[p*`SMRC_PORT_W +: `SMRC_PORT_W]),
      .data(port_data[p*`SMRC_PORT_W +: `SMRC_PORT_W]),
      .force_pu(jtag_pu[p*`SMRC_PORT_W +: `SMRC_PORT_W]),
      .pin_o(pin_o[p*`SMRC_PORT_W +: `SMRC_PORT_W]),
      .pin_oe_n(pin_oe_n[p*`SMRC_PORT_W +: `SMRC_PORT_W]),
      .pu_en(pu_en[p*`SMRC_PORT_W +: `SMRC_PORT_W])
    );
  end
endmodule

//--- tb/smrc_properties.sv
// Checker for the sleep mode and reset controller
`timescale 1ns/1ps
`include "smrc_defs.svh"
module smrc_properties
  import smrc_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic reset, // Async reset
  input wire logic ext_rst_n, // Reset pin
  input wire logic sleep_en, // Sleep enable
  input wire logic sleep_instr, // Sleep pulse
  input wire logic [`SMRC_MODE_W-1:0] sleep_mode, // Mode
  input wire smrc_wake_t wake, // Wake sources
  input wire logic [3:0] tap_state, // TAP state
  input wire smrc_gate_t gate_q, // Gates
  input wire smrc_state_t state_q, // State
  input wire logic sys_rst_q, // Internal reset
  input wire logic tdo_oe_n_q, // TDO enable
  input wire logic [`SMRC_NPORT*`SMRC_PORT_W-1:0] pin_oe_n // Pin enables
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset || sys_rst_q);
  logic [4:0] pat;
  logic go;
  logic [6:0] low_q;
  // Gate pattern of each defined mode
  assign pat = sleep_mode == 3'h0 ? 5'h0F : sleep_mode == 3'h1 ? 5'h0E :
    sleep_mode == 3'h3 ? 5'h04 : sleep_mode == 3'h6 ? 5'h08 :
    sleep_mode == 3'h7 ? 5'h0C : 5'h00;
  assign go = state_q == SMRC_RUN && sleep_en && sleep_instr;
  // Length of the present low level on the reset pin
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) low_q <= 7'h00;
    else if (ext_rst_n) low_q <= 7'h00;
    else if (low_q != 7'h7F) low_q <= low_q + 7'h01;
  end
  a_sleep_entry: assert property (go && sleep_mode[2:1] != 2'h2 |=>
    state_q == SMRC_SLEEP && gate_q == $past(pat)) else $error("sleep entry wrong");
  a_sleep_refused: assert property (state_q == SMRC_RUN && !sleep_en |=>
    state_q != SMRC_SLEEP) else $error("sleep without enable");
  a_gates_stand: assert property (state_q == SMRC_SLEEP ##1 state_q == SMRC_SLEEP
    |-> $stable(gate_q)) else $error("gates moved in sleep");
  a_pdown_wake: assert property (state_q == SMRC_SLEEP && gate_q == 5'h00 &&
    !wake.ext_int |=> state_q == SMRC_SLEEP) else $error("power-down woke");
  a_wake_restore: assert property (state_q == SMRC_WAKE |-> gate_q == 5'h1F
    ##1 state_q == SMRC_RUN) else $error("wake sequence wrong");
  a_reset_tristate: assert property (disable iff (1'h0) sys_rst_q || reset
    |-> pin_oe_n == '1) else $error("pins driven in reset");
  a_tdo_idle: assert property ($past(tap_state) != 4'h4 &&
    $past(tap_state) != 4'hB |-> tdo_oe_n_q) else $error("tdo driven");
  a_pin_reset: assert property (disable iff (reset) low_q >= 7'h50 |-> sys_rst_q)
    else $error("reset pin ignored");
  c_sleep: cover property (go ##1 state_q == SMRC_SLEEP);
  c_wake: cover property (state_q == SMRC_WAKE);
  c_pin_rst: cover property (low_q == 7'h50);
endmodule
bind smrc_top smrc_properties i_props (.core_clk, .reset, .ext_rst_n, .sleep_en,
  .sleep_instr, .sleep_mode, .wake, .tap_state, .gate_q, .state_q, .sys_rst_q,
  .tdo_oe_n_q, .pin_oe_n);

//--- tb/smrc_rst_src.sv
// Model of the external party driving the reset pin
`timescale 1ns/1ps
module smrc_rst_src
(
  input wire logic core_clk, // Clock
  input wire logic req, // Reset request pulse
  output logic ext_rst_n // Reset pin
);
  logic [7:0] cnt_q = 8'hFF;
  // Low for a full 90 cycles after any request
  always @(posedge core_clk) begin
    if (req) cnt_q <= 8'h00;
    else if (cnt_q != 8'hFF) cnt_q <= cnt_q + 8'h01;
  end
  assign ext_rst_n = !req && cnt_q >= 8'h5A;
endmodule

//--- tb/testbench.sv
// Self-checking bench for the sleep mode and reset controller
`timescale 1ns/1ps
module testbench;
  import smrc_pkg::*;
  logic core_clk = 1'h1, reset = 1'h0, rst_req = 1'h0, sleep_en = 1'h0;
  logic sleep_instr = 1'h0, jtag_en = 1'h1, tap_tdo = 1'h0, ext_rst_n;
  logic [2:0] sleep_mode = 3'h0;
  logic [3:0] tap_state = 4'h0;
  logic [31:0] port_dir = 32'h0, port_data = 32'h0, pin_o, pin_oe_n, pu_en;
  smrc_wake_t wake = 4'h0;
  smrc_gate_t gate_q;
  smrc_state_t state_q;
  logic sys_rst_q, tdo_o_q, tdo_oe_n_q;
  int err_total = 0, checked = 0;
  always #10 core_clk = ~core_clk;
  smrc_rst_src i_src (.core_clk, .req(rst_req), .ext_rst_n);
  smrc_top i_dut (.core_clk, .reset, .ext_rst_n, .sleep_en, .sleep_instr, .sleep_mode,
    .wake, .jtag_en, .tap_state, .tap_tdo, .port_dir, .port_data, .gate_q, .state_q,
    .sys_rst_q, .tdo_o_q, .tdo_oe_n_q, .pin_o, .pin_oe_n, .pu_en);
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Request sleep in one mode, wake by the pin interrupt
  task automatic t_mode(input logic [2:0] m, input logic [4:0] pat);
    sleep_mode = m;
    sleep_en = 1'h1;
    sleep_instr = 1'h1;
    cyc(1);
    sleep_instr = 1'h0;
    chk("state", state_q, SMRC_SLEEP);
    chk("gates", gate_q, pat);
    wake.ext_int = 1'h1;
    cyc(1);
    wake.ext_int = 1'h0;
    chk("woken", gate_q, 5'h1F);
    cyc(2);
    chk("run", state_q, SMRC_RUN);
  endtask
  // Refused sleep, then power-down ignoring the timer wake
  task automatic t_refuse;
    sleep_en = 1'h0;
    sleep_instr = 1'h1;
    cyc(1);
    chk("no_en", state_q, SMRC_RUN);
    sleep_mode = 3'h2;
    sleep_en = 1'h1;
    cyc(1);
    sleep_instr = 1'h0;
    wake.atimer_int = 1'h1;
    cyc(3);
    wake.atimer_int = 1'h0;
    chk("pd_hold", state_q, SMRC_SLEEP);
  endtask
  // Noise reduction ignores port wake, wakes on the converter
  task automatic t_wake;
    sleep_mode = 3'h1;
    sleep_instr = 1'h1;
    cyc(1);
    sleep_instr = 1'h0;
    wake.io_int = 1'h1;
    cyc(2);
    wake.io_int = 1'h0;
    chk("nr_hold", state_q, SMRC_SLEEP);
    wake.adc_int = 1'h1;
    cyc(1);
    wake.adc_int = 1'h0;
    chk("nr_wake", state_q, SMRC_WAKE);
    cyc(2);
  endtask
  // Port pins with JTAG pull-ups, then the shift states of TDO
  task automatic t_pins;
    port_dir = 32'hF0F0_0F0F;
    port_data = 32'hAAAA_5555;
    tap_state = 4'h4;
    tap_tdo = 1'h1;
    cyc(3);
    chk("oe_n", pin_oe_n, 32'h0F0F_F0F0);
    chk("pin_o", pin_o, 32'hAAAA_5555);
    chk("tdo_val", tdo_o_q, 1'h1);
    chk("pull", pu_en, 32'h0A2E_5050);
    chk("tdo_dr", tdo_oe_n_q, 1'h0);
    tap_state = 4'hB;
    cyc(2);
    chk("tdo_ir", tdo_oe_n_q, 1'h0);
    tap_state = 4'h3;
    cyc(2);
    chk("tdo_off", tdo_oe_n_q, 1'h1);
  endtask
  // Reset pin pulse from the model, then release
  task automatic t_ext;
    rst_req = 1'h1;
    cyc(1);
    rst_req = 1'h0;
    cyc(85);
    chk("sysrst", sys_rst_q, 1'h1);
    chk("tri", pin_oe_n, 32'hFFFF_FFFF);
    chk("jtag_pu", pu_en & 32'h002C_0000, 32'h002C_0000);
    chk("pd_exit", state_q, SMRC_RUN);
    cyc(15);
    chk("rel", sys_rst_q, 1'h0);
  endtask
  // Clock starts high so reset rises before the first rising edge
  initial begin
    cyc(1);
    reset = 1'h1;
    cyc(1);
    chk("por_tri", pin_oe_n, 32'hFFFF_FFFF);
    cyc(11);
    reset = 1'h0;
    cyc(2);
    t_pins;
    t_mode(3'h0, 5'h0F);
    t_mode(3'h1, 5'h0E);
    t_mode(3'h2, 5'h00);
    t_mode(3'h3, 5'h04);
    t_mode(3'h6, 5'h08);
    t_mode(3'h7, 5'h0C);
    t_mode(3'h4, 5'h1F);
    t_wake;
    t_refuse;
    t_ext;
    end_of_test;
  end
  // Watchdog well past the expected run length
  initial begin
    cyc(2000);
    err_total++;
    end_of_test;
  end
endmodule
